// ### inc/core_state_pkg.sv
// Constants and types shared by the core state register block.
//
// Contract
// - Fetch next instruction while current one executes.
// - Thirty-two eight-bit registers, single-cycle access.
// - Read two operands, compute, write back, one cycle.
// - Top six registers form three 16-bit pointers.
// - Pointers support displacement, post-increment, pre-decrement.
// - Register file occupies lowest 32 data addresses.
// - I/O space reachable directly and at 0x20-0x5F.
// - Bit 7 gates every interrupt.
// - Taking interrupt clears bit 7; return sets it.
// - Bit 6 stores and loads one register bit.
// - Bit 5 records low nibble carry.
// - Bit 4 equals negative XOR overflow.
// - Bit 3 flags two's complement overflow.
// - Bits 2,1,0 hold negative, zero, carry.
// - Flags update after every ALU operation.
// - Status never saved or restored by hardware.
// - Byte push decrements, pop increments by one.
// - Calls and returns move stack pointer by two.
// - Stack pointer is two readable, writable I/O bytes.
// - Lower vector address means higher interrupt priority.
// - Core clock used undivided.
package core_state_pkg;
  localparam int unsigned REG_COUNT = 32;
  localparam int unsigned IO_COUNT = 64;
  localparam int unsigned IRQ_COUNT = 8;
  localparam logic [15:0] IO_BASE_ADDR = 16'h0020;
  localparam logic [15:0] IO_END_ADDR = 16'h005F;
  localparam logic [5:0] IO_STATUS_FLAGS = 6'h3F;
  localparam logic [5:0] IO_STACK_POINTER_HIGH = 6'h3E;
  localparam logic [5:0] IO_STACK_POINTER_LOW = 6'h3D;
  localparam logic [4:0] PTR_A_LOW = 5'h1A;
  localparam logic [4:0] PTR_B_LOW = 5'h1C;
  localparam logic [4:0] PTR_C_LOW = 5'h1E;
  localparam int unsigned FLAG_IE = 7;
  localparam int unsigned FLAG_T = 6;
  localparam int unsigned FLAG_H = 5;
  localparam int unsigned FLAG_S = 4;
  localparam int unsigned FLAG_V = 3;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_C = 0;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam logic [15:0] INSTR_RESET = 16'h0000;
  typedef enum logic [3:0] {
    ALU_NONE = 4'h0,
    ALU_ADD = 4'h1,
    ALU_ADC = 4'h2,
    ALU_SUB = 4'h3,
    ALU_SBC = 4'h4,
    ALU_AND = 4'h5,
    ALU_OR = 4'h6,
    ALU_XOR = 4'h7,
    ALU_MOV = 4'h8,
    ALU_INC = 4'h9,
    ALU_DEC = 4'hA
  } alu_op_t;
  typedef enum logic [2:0] {
    SP_HOLD = 3'h0,
    SP_PUSH1 = 3'h1,
    SP_POP1 = 3'h2,
    SP_PUSH2 = 3'h3,
    SP_POP2 = 3'h4
  } sp_op_t;
  typedef enum logic [1:0] {
    PTR_DISP = 2'h0,
    PTR_POST_INC = 2'h1,
    PTR_PRE_DEC = 2'h2
  } ptr_mode_t;
endpackage

// ### hdl/core_alu.sv
`timescale 1ns/1ps
// Single-cycle ALU producing a result and the arithmetic flags.
module core_alu (
  input wire core_state_pkg::alu_op_t op_i,
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  input wire logic carry_i,
  output logic [7:0] res_o,
  output logic [5:0] flags_o
);
  import core_state_pkg::*;
  logic [8:0] sum;
  logic [4:0] nib;
  logic v;
  logic n;
  logic arith;
  always_comb begin
    sum = {1'b0, a_i};
    nib = {1'b0, a_i[3:0]};
    v = 1'b0;
    arith = 1'b1;
    case (op_i)
      ALU_ADD, ALU_ADC: begin
        sum = {1'b0, a_i} + {1'b0, b_i} + {8'h00, (op_i == ALU_ADC) & carry_i};
        nib = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, (op_i == ALU_ADC) & carry_i};
        v = (a_i[7] == b_i[7]) && (sum[7] != a_i[7]);
      end
      ALU_SUB, ALU_SBC: begin
        sum = {1'b0, a_i} - {1'b0, b_i} - {8'h00, (op_i == ALU_SBC) & carry_i};
        nib = {1'b0, a_i[3:0]} - {1'b0, b_i[3:0]} - {4'h0, (op_i == ALU_SBC) & carry_i};
        v = (a_i[7] != b_i[7]) && (sum[7] != a_i[7]);
      end
      ALU_INC: begin
        sum = {carry_i, a_i + 8'h01};
        v = (a_i == 8'h7F);
      end
      ALU_DEC: begin
        sum = {carry_i, a_i - 8'h01};
        v = (a_i == 8'h80);
      end
      ALU_AND: begin
        sum = {carry_i, a_i & b_i};
        arith = 1'b0;
      end
      ALU_OR: begin
        sum = {carry_i, a_i | b_i};
        arith = 1'b0;
      end
      ALU_XOR: begin
        sum = {carry_i, a_i ^ b_i};
        arith = 1'b0;
      end
      ALU_MOV: begin
        sum = {carry_i, b_i};
        arith = 1'b0;
      end
      default: begin
        sum = {carry_i, a_i};
        arith = 1'b0;
      end
    endcase
    res_o = sum[7:0];
    n = sum[7];
    // Flag order matches status bits 5 down to 0; logic ops leave half carry at zero.
    flags_o[5] = arith & nib[4];
    flags_o[4] = n ^ v;
    flags_o[3] = v;
    flags_o[2] = n;
    flags_o[1] = (sum[7:0] == 8'h00);
    flags_o[0] = sum[8];
  end
endmodule

// ### hdl/cpu_core_state_regs.sv
`timescale 1ns/1ps
// Architectural state of the core: fetch stage, register file, status and stack pointer.
module cpu_core_state_regs (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic [15:0] fetch_word_i,
  input wire logic fetch_valid_i,
  input wire core_state_pkg::alu_op_t alu_op_i,
  input wire logic [4:0] dst_sel_i,
  input wire logic [4:0] src_sel_i,
  input wire logic use_imm_i,
  input wire logic [7:0] imm_i,
  input wire logic bit_store_i,
  input wire logic bit_load_i,
  input wire logic [2:0] bit_idx_i,
  input wire logic set_ie_i,
  input wire logic clear_ie_i,
  input wire logic irq_taken_i,
  input wire logic irq_return_i,
  input wire core_state_pkg::sp_op_t sp_op_i,
  input wire logic ptr_en_i,
  input wire logic [1:0] ptr_sel_i,
  input wire core_state_pkg::ptr_mode_t ptr_mode_i,
  input wire logic [5:0] ptr_disp_i,
  input wire logic data_wr_i,
  input wire logic data_rd_i,
  input wire logic [15:0] data_addr_i,
  input wire logic [7:0] data_wdata_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [5:0] io_addr_i,
  input wire logic [7:0] io_rdata_i,
  input wire logic [core_state_pkg::IRQ_COUNT-1:0] irq_req_i,
  output logic [15:0] instr_o,
  output logic [7:0] data_rdata_o,
  output logic [15:0] ptr_addr_o,
  output logic [15:0] table_addr_o,
  output logic [7:0] status_o,
  output logic [15:0] stack_pointer_o,
  output logic irq_pending_o,
  output logic [2:0] irq_vector_o,
  output logic [5:0] periph_addr_o,
  output logic [7:0] periph_wdata_o,
  output logic periph_wr_o,
  output logic periph_rd_o
);
  import core_state_pkg::*;

  logic [7:0] regs_q [REG_COUNT];
  logic [7:0] status_q;
  logic [15:0] sp_q;
  logic [15:0] instr_q;
  logic [7:0] rdata_q;
  logic [15:0] ptr_addr_q;
  logic [15:0] table_addr_q;
  logic irq_pending_q;
  logic [2:0] irq_vector_q;
  logic [5:0] periph_addr_q;
  logic [7:0] periph_wdata_q;
  logic periph_wr_q;
  logic periph_rd_q;
  logic [7:0] op_a;
  logic [7:0] op_b;
  logic [7:0] alu_res;
  logic [5:0] alu_flags;
  logic [4:0] ptr_low;
  logic [15:0] ptr_cur;
  logic [15:0] ptr_next;
  logic [15:0] ptr_eff;
  logic mem_reg_hit;
  logic mem_io_hit;
  logic [5:0] mem_io_addr;
  logic io_hit;
  logic [5:0] io_sel;
  logic io_we;
  logic io_re;
  logic [7:0] io_wdata;
  logic [2:0] irq_first;
  logic irq_any;
  logic status_wr;
  logic spl_wr;
  logic sph_wr;
  logic io_own;
  logic ptr_upd;

  // Operands are read combinationally so the ALU finishes in the same cycle.
  assign op_a = regs_q[dst_sel_i];
  assign op_b = use_imm_i ? imm_i : regs_q[src_sel_i];

  core_alu u_alu (
    .op_i(alu_op_i),
    .a_i(op_a),
    .b_i(op_b),
    .carry_i(status_q[FLAG_C]),
    .res_o(alu_res),
    .flags_o(alu_flags)
  );

  // Pointer pair selection and address generation.
  always_comb begin
    case (ptr_sel_i)
      2'h0: ptr_low = PTR_A_LOW;
      2'h1: ptr_low = PTR_B_LOW;
      default: ptr_low = PTR_C_LOW;
    endcase
    ptr_cur = {regs_q[ptr_low + 5'h01], regs_q[ptr_low]};
    case (ptr_mode_i)
      PTR_POST_INC: begin
        ptr_eff = ptr_cur;
        ptr_next = ptr_cur + 16'h0001;
      end
      PTR_PRE_DEC: begin
        ptr_eff = ptr_cur - 16'h0001;
        ptr_next = ptr_cur - 16'h0001;
      end
      default: begin
        ptr_eff = ptr_cur + {10'h000, ptr_disp_i};
        ptr_next = ptr_cur;
      end
    endcase
  end

  // Data-space decode: registers low, then the I/O window.
  assign mem_reg_hit = (data_addr_i < 16'(REG_COUNT));
  assign mem_io_hit = (data_addr_i >= IO_BASE_ADDR) && (data_addr_i <= IO_END_ADDR);
  assign mem_io_addr = 6'(data_addr_i - IO_BASE_ADDR);
  assign io_hit = io_wr_i | io_rd_i;
  assign io_sel = io_hit ? io_addr_i : mem_io_addr;
  assign io_we = io_wr_i | (data_wr_i & mem_io_hit);
  assign io_re = io_rd_i | (data_rd_i & mem_io_hit);
  assign io_wdata = data_wdata_i;

  // Writes to the core's own I/O bytes are decoded once and shared below.
  assign status_wr = io_we && io_sel == IO_STATUS_FLAGS;
  assign spl_wr = io_we && io_sel == IO_STACK_POINTER_LOW;
  assign sph_wr = io_we && io_sel == IO_STACK_POINTER_HIGH;
  assign io_own = io_sel == IO_STATUS_FLAGS || io_sel == IO_STACK_POINTER_LOW
    || io_sel == IO_STACK_POINTER_HIGH;
  assign ptr_upd = ptr_en_i && ptr_mode_i != PTR_DISP;

  // Register file writes; ALU result wins over a data-space store to the same cycle.
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_q[i] <= 8'h00;
      end
    end else begin
      if (ptr_upd) begin
        regs_q[ptr_low] <= ptr_next[7:0];
        regs_q[ptr_low + 5'h01] <= ptr_next[15:8];
      end
      if (data_wr_i && mem_reg_hit) begin
        regs_q[data_addr_i[4:0]] <= data_wdata_i;
      end
      if (bit_load_i) begin
        regs_q[dst_sel_i][bit_idx_i] <= status_q[FLAG_T];
      end else if (alu_op_i != ALU_NONE) begin
        regs_q[dst_sel_i] <= alu_res;
      end
    end
  end

  // Status flags. Interrupt entry is not allowed to touch the result flags.
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      status_q <= STATUS_RESET;
    end else if (status_wr) begin
      // A taken interrupt still drops the enable while software rewrites the byte.
      status_q <= {io_wdata[FLAG_IE] & ~irq_taken_i, io_wdata[6:0]};
    end else begin
      if (alu_op_i != ALU_NONE) begin
        status_q[5:0] <= alu_flags;
      end
      if (bit_store_i) begin
        status_q[FLAG_T] <= op_a[bit_idx_i];
      end
      if (irq_taken_i || clear_ie_i) begin
        status_q[FLAG_IE] <= 1'b0;
      end else if (irq_return_i || set_ie_i) begin
        status_q[FLAG_IE] <= 1'b1;
      end
    end
  end

  // Stack pointer grows downward; software writes take priority.
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sp_q <= SP_RESET;
    end else if (spl_wr) begin
      sp_q[7:0] <= io_wdata;
    end else if (sph_wr) begin
      sp_q[15:8] <= io_wdata;
    end else begin
      case (sp_op_i)
        SP_PUSH1: sp_q <= sp_q - 16'h0001;
        SP_POP1: sp_q <= sp_q + 16'h0001;
        SP_PUSH2: sp_q <= sp_q - 16'h0002;
        SP_POP2: sp_q <= sp_q + 16'h0002;
        default: sp_q <= sp_q;
      endcase
    end
  end

  // Prefetch register: the next word is latched while the current one executes.
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      instr_q <= INSTR_RESET;
    end else if (fetch_valid_i) begin
      instr_q <= fetch_word_i;
    end
  end

  // Peripheral forwarding; the core's own bytes are never passed on as peripheral writes.
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      periph_addr_q <= 6'h00;
      periph_wdata_q <= 8'h00;
      periph_wr_q <= 1'b0;
      periph_rd_q <= 1'b0;
    end else begin
      periph_addr_q <= io_sel;
      periph_wdata_q <= io_wdata;
      periph_wr_q <= io_we && !io_own;
      periph_rd_q <= io_re;
    end
  end

  // Read data stands one cycle and then returns to zero, so a stale byte is never re-read.
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_q <= 8'h00;
    end else if (data_rd_i && mem_reg_hit) begin
      rdata_q <= regs_q[data_addr_i[4:0]];
    end else if (io_re && io_sel == IO_STATUS_FLAGS) begin
      rdata_q <= status_q;
    end else if (io_re && io_sel == IO_STACK_POINTER_LOW) begin
      rdata_q <= sp_q[7:0];
    end else if (io_re && io_sel == IO_STACK_POINTER_HIGH) begin
      rdata_q <= sp_q[15:8];
    end else if (io_re) begin
      rdata_q <= io_rdata_i;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // Effective address of the pointer pair selected in this cycle.
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ptr_addr_q <= 16'h0000;
    end else begin
      ptr_addr_q <= ptr_eff;
    end
  end

  // The third pair also addresses program-memory tables.
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      table_addr_q <= 16'h0000;
    end else begin
      table_addr_q <= {regs_q[PTR_C_LOW + 5'h01], regs_q[PTR_C_LOW]};
    end
  end

  // Lowest request index wins, which is the lowest vector address.
  always_comb begin
    irq_first = 3'h0;
    irq_any = 1'b0;
    for (int i = IRQ_COUNT - 1; i >= 0; i--) begin
      if (irq_req_i[i]) begin
        irq_first = 3'(i);
        irq_any = 1'b1;
      end
    end
  end

  // A disable or an interrupt entry in the same cycle masks pending at once.
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_pending_q <= 1'b0;
    end else begin
      irq_pending_q <= irq_any && status_q[FLAG_IE] && !clear_ie_i && !irq_taken_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_vector_q <= 3'h0;
    end else begin
      irq_vector_q <= irq_first;
    end
  end

  assign instr_o = instr_q;
  assign data_rdata_o = rdata_q;
  assign ptr_addr_o = ptr_addr_q;
  assign table_addr_o = table_addr_q;
  assign status_o = status_q;
  assign stack_pointer_o = sp_q;
  assign irq_pending_o = irq_pending_q;
  assign irq_vector_o = irq_vector_q;
  assign periph_addr_o = periph_addr_q;
  assign periph_wdata_o = periph_wdata_q;
  assign periph_wr_o = periph_wr_q;
  assign periph_rd_o = periph_rd_q;
endmodule

// ### verification/core_partner_model.sv
`timescale 1ns/1ps
// Program memory and peripheral space model facing the core state block.
module core_partner_model (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic [5:0] periph_addr_i,
  input wire logic periph_rd_i,
  output logic [15:0] fetch_word_o,
  output logic fetch_valid_o,
  output logic [7:0] io_rdata_o
);
  logic [15:0] pc_q;
  // Every fourth cycle memory stalls and shows a changing word, so a stale latch is seen.
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pc_q <= 16'h0000;
      fetch_valid_o <= 1'b0;
      fetch_word_o <= 16'h0000;
      io_rdata_o <= 8'h00;
    end else begin
      pc_q <= pc_q + 16'h0001;
      fetch_valid_o <= pc_q[1:0] != 2'h3;
      fetch_word_o <= (pc_q[1:0] != 2'h3) ? pc_q * 16'h9E37 : ~fetch_word_o;
      io_rdata_o <= periph_rd_i ? {2'h0, periph_addr_i} ^ 8'hC3 : ~io_rdata_o;
    end
  end
endmodule

// ### verification/cpu_core_state_regs_asserts.sv
`timescale 1ns/1ps
// Port-level assertions for the core state register block.
module cpu_core_state_regs_asserts (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic [15:0] fetch_word_i,
  input wire logic fetch_valid_i,
  input wire core_state_pkg::alu_op_t alu_op_i,
  input wire logic set_ie_i,
  input wire logic clear_ie_i,
  input wire logic irq_taken_i,
  input wire logic irq_return_i,
  input wire core_state_pkg::sp_op_t sp_op_i,
  input wire logic data_wr_i,
  input wire logic data_rd_i,
  input wire logic [15:0] data_addr_i,
  input wire logic io_wr_i,
  input wire logic [core_state_pkg::IRQ_COUNT-1:0] irq_req_i,
  input wire logic [15:0] instr_o,
  input wire logic [7:0] data_rdata_o,
  input wire logic [7:0] status_o,
  input wire logic [15:0] stack_pointer_o,
  input wire logic irq_pending_o,
  input wire logic [2:0] irq_vector_o
);
  import core_state_pkg::*;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  // Status and stack writes through I/O win over same-cycle updates, so they are excluded.
  sequence s_sp_step(sp_op_t op);
    sp_op_i == op && !io_wr_i && !data_wr_i;
  endsequence
  sequence s_status_read;
    data_rd_i && data_addr_i == 16'h005F && !data_wr_i;
  endsequence
  a_fetch_overlap: assert property (
    1'b1 |=> instr_o == ($past(fetch_valid_i) ? $past(fetch_word_i) : $past(instr_o)))
    else $error("prefetch word wrong");
  a_sign_relation: assert property (
    alu_op_i != ALU_NONE && !io_wr_i && !data_wr_i |=> status_o[4] == (status_o[2] ^ status_o[3]))
    else $error("sign flag wrong");
  a_ie_drop: assert property (
    (irq_taken_i || clear_ie_i) && !io_wr_i && !data_wr_i |=> !status_o[7])
    else $error("enable not cleared");
  a_ie_raise: assert property (
    (set_ie_i || irq_return_i) && !irq_taken_i && !clear_ie_i && !io_wr_i && !data_wr_i
    |=> status_o[7])
    else $error("enable not set");
  a_irq_gate: assert property (
    !status_o[7] && !$past(status_o[7]) |-> !irq_pending_o)
    else $error("pending while disabled");
  a_irq_order: assert property (
    irq_pending_o |-> ($past(irq_req_i) & (8'h01 << irq_vector_o)) != 8'h00
    && ($past(irq_req_i) & ((8'h01 << irq_vector_o) - 8'h01)) == 8'h00)
    else $error("vector not highest priority");
  a_sp_push1: assert property (
    s_sp_step(SP_PUSH1) |=> stack_pointer_o == $past(stack_pointer_o) - 16'h0001)
    else $error("push did not step by one");
  a_sp_pop2: assert property (
    s_sp_step(SP_POP2) |=> stack_pointer_o == $past(stack_pointer_o) + 16'h0002)
    else $error("return did not step by two");
  a_status_window: assert property (
    s_status_read |=> data_rdata_o == $past(status_o))
    else $error("status read wrong");
endmodule
bind cpu_core_state_regs cpu_core_state_regs_asserts u_chk (.core_clk_i, .arst_n_i,
  .fetch_word_i, .fetch_valid_i, .alu_op_i, .set_ie_i, .clear_ie_i, .irq_taken_i,
  .irq_return_i, .sp_op_i, .data_wr_i, .data_rd_i, .data_addr_i, .io_wr_i, .irq_req_i,
  .instr_o, .data_rdata_o, .status_o, .stack_pointer_o, .irq_pending_o, .irq_vector_o);

// ### verification/tb.sv
`timescale 1ns/1ps
// Self-checking bench comparing the state block with a bench model.
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin failures++; $display("ERROR %s expected %0h seen %0h", n, e, s); end end
module tb;
  import core_state_pkg::*;
  logic core_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic fetch_valid_i, use_imm_i, bit_store_i, bit_load_i, set_ie_i, clear_ie_i, irq_taken_i;
  logic irq_return_i, ptr_en_i, data_wr_i, data_rd_i, io_wr_i, io_rd_i, irq_pending_o;
  logic periph_wr_o, periph_rd_o;
  logic [15:0] fetch_word_i, data_addr_i, instr_o, ptr_addr_o, table_addr_o, stack_pointer_o;
  logic [7:0] imm_i, data_wdata_i, io_rdata_i, irq_req_i, data_rdata_o, status_o, periph_wdata_o;
  logic [5:0] ptr_disp_i, io_addr_i, periph_addr_o;
  logic [4:0] dst_sel_i, src_sel_i;
  logic [2:0] bit_idx_i, irq_vector_o;
  logic [1:0] ptr_sel_i;
  alu_op_t alu_op_i;
  sp_op_t sp_op_i;
  ptr_mode_t ptr_mode_i;
  int failures = 0;
  int compares = 0;
  int reg_m [32];
  int st_m = 0;
  int sp_m = 0;
  int dq [$] = '{-1, 1, -2, 2};
  int p;
  logic [15:0] instr_m = 16'h0000;
  always #2.5 core_clk_i = ~core_clk_i;
  cpu_core_state_regs dut (.core_clk_i, .arst_n_i, .fetch_word_i, .fetch_valid_i, .alu_op_i,
    .dst_sel_i, .src_sel_i, .use_imm_i, .imm_i, .bit_store_i, .bit_load_i, .bit_idx_i,
    .set_ie_i, .clear_ie_i, .irq_taken_i, .irq_return_i, .sp_op_i, .ptr_en_i, .ptr_sel_i,
    .ptr_mode_i, .ptr_disp_i, .data_wr_i, .data_rd_i, .data_addr_i, .data_wdata_i, .io_wr_i,
    .io_rd_i, .io_addr_i, .io_rdata_i, .irq_req_i, .instr_o, .data_rdata_o, .ptr_addr_o,
    .table_addr_o, .status_o, .stack_pointer_o, .irq_pending_o, .irq_vector_o,
    .periph_addr_o, .periph_wdata_o, .periph_wr_o, .periph_rd_o);
  core_partner_model far (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
    .periph_addr_i(periph_addr_o), .periph_rd_i(periph_rd_o), .fetch_word_o(fetch_word_i),
    .fetch_valid_o(fetch_valid_i), .io_rdata_o(io_rdata_i));
  task automatic clr();
    {bit_store_i, bit_load_i, set_ie_i, clear_ie_i, irq_taken_i, irq_return_i, ptr_en_i,
      data_wr_i, data_rd_i, io_wr_i, io_rd_i, use_imm_i} = '0;
    alu_op_i = ALU_NONE;
    sp_op_i = SP_HOLD;
  endtask
  // Strobes last one edge; results are sampled 1 ns after it, once updates have landed.
  task automatic tick();
    logic fv;
    logic [15:0] fw;
    fv = fetch_valid_i;
    fw = fetch_word_i;
    @(posedge core_clk_i);
    #1;
    clr();
    if (fv) instr_m = fw;
    `CHK("instr_o", instr_m, instr_o)
  endtask
  function automatic int mexp(int a);
    return a < 32 ? reg_m[a] : a == 'h5D ? sp_m % 256 : a == 'h5E ? sp_m / 256 : st_m;
  endfunction
  task automatic mwr(int a, int d);
    if (a < 32) reg_m[a] = d;
    else if (a == 'h5D) sp_m = sp_m / 256 * 256 + d;
    else if (a == 'h5E) sp_m = d * 256 + sp_m % 256;
    else if (a == 'h5F) st_m = d;
  endtask
  task automatic dwrite(int a, int d);
    data_wr_i = 1'b1;
    data_addr_i = 16'(a);
    data_wdata_i = 8'(d);
    tick();
    mwr(a, d);
  endtask
  task automatic dchk(int a);
    data_rd_i = 1'b1;
    data_addr_i = 16'(a);
    tick();
    `CHK("data_rdata_o", 8'(mexp(a)), data_rdata_o)
  endtask
  task automatic iowr(int a, int d);
    io_wr_i = 1'b1;
    io_addr_i = 6'(a);
    data_wdata_i = 8'(d);
    tick();
    mwr(a + 32, d);
    `CHK("periph_wr_o", 1'(a < 'h3D), periph_wr_o)
    `CHK("periph_addr_o", 6'(a), periph_addr_o)
    `CHK("periph_wdata_o", 8'(d), periph_wdata_o)
  endtask
  task automatic alu(int d, int s, bit imm);
    alu_op_t op;
    int a, b, c, r, h, cy, v, n;
    op = alu_op_t'(1 + $urandom % 10);
    a = reg_m[d];
    b = imm ? $urandom % 256 : reg_m[s];
    c = (op == ALU_ADC || op == ALU_SBC) ? st_m % 2 : 0;
    cy = st_m % 2;
    h = 0;
    v = 0;
    case (op)
      ALU_ADD, ALU_ADC: begin
        r = (a + b + c) & 255;
        h = a % 16 + b % 16 + c > 15;
        cy = a + b + c > 255;
        v = ~(a ^ b) & (a ^ r) & 128;
      end
      ALU_SUB, ALU_SBC: begin
        r = (a - b - c) & 255;
        h = a % 16 < b % 16 + c;
        cy = a < b + c;
        v = (a ^ b) & (a ^ r) & 128;
      end
      ALU_AND: r = a & b;
      ALU_OR: r = a | b;
      ALU_XOR: r = a ^ b;
      ALU_MOV: r = b;
      ALU_INC: begin
        r = (a + 1) & 255;
        v = (a == 127) * 128;
      end
      default: begin
        r = (a - 1) & 255;
        v = (a == 128) * 128;
      end
    endcase
    v = v / 128;
    n = r / 128;
    alu_op_i = op;
    dst_sel_i = 5'(d);
    src_sel_i = 5'(s);
    use_imm_i = imm;
    imm_i = 8'(b);
    tick();
    reg_m[d] = r;
    st_m = st_m / 64 * 64 + h * 32 + (n ^ v) * 16 + v * 8 + n * 4 + (r == 0) * 2 + cy;
    `CHK("status_o", 8'(st_m), status_o)
    dchk(d);
  endtask
  task automatic conclude();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #20000;
    failures++;
    conclude();
  end
  initial begin
    void'($urandom(40103));
    clr();
    {dst_sel_i, src_sel_i, imm_i, bit_idx_i, ptr_sel_i, ptr_disp_i, data_addr_i, data_wdata_i,
      io_addr_i, irq_req_i} = '0;
    ptr_mode_i = PTR_DISP;
    repeat (4) @(posedge core_clk_i);
    #1;
    arst_n_i = 1'b1;
    `CHK("status_o", 8'h00, status_o)
    for (int i = 0; i < 32; i++) dwrite(i, $urandom % 256);
    for (int i = 0; i < 32; i += 3) dchk(i);
    iowr('h3D, 'h60);
    iowr('h3E, 'h02);
    iowr('h10, 'h3C);
    for (int i = 0; i < 8; i++) begin
      sp_op_i = sp_op_t'(i % 4 + 1);
      sp_m += dq[i % 4];
      tick();
      `CHK("stack_pointer_o", 16'(sp_m), stack_pointer_o)
    end
    dchk('h5D);
    dchk('h5E);
    repeat (32) alu($urandom % 32, $urandom % 32, 1'($urandom % 2));
    for (int k = 0; k < 8; k++) begin
      bit_store_i = 1'b1;
      dst_sel_i = 5'(k + 3);
      bit_idx_i = 3'(k);
      tick();
      st_m[6] = reg_m[k + 3][k];
      bit_load_i = 1'b1;
      dst_sel_i = 5'h02;
      tick();
      reg_m[2][k] = st_m[6];
      `CHK("status_o", 8'(st_m), status_o)
    end
    dchk(2);
    irq_req_i = 8'h28;
    for (int k = 0; k < 4; k++) begin
      {set_ie_i, irq_taken_i, irq_return_i, clear_ie_i} = 4'b1000 >> k;
      st_m[7] = k % 2 == 0;
      tick();
      `CHK("status_o", 8'(st_m), status_o)
      tick();
      `CHK("irq_pending_o", 1'(st_m[7]), irq_pending_o)
    end
    dwrite('h5F, 'h80);
    dchk('h5F);
    for (int k = 0; k < 8; k++) begin
      irq_req_i = 8'h80 >> k | 8'h80;
      tick();
      tick();
      `CHK("irq_vector_o", 3'(7 - k), irq_vector_o)
    end
    dwrite(28, 'hFF);
    dwrite(29, 'h00);
    for (int k = 0; k < 3; k++) begin
      p = reg_m[29] * 256 + reg_m[28];
      ptr_en_i = 1'b1;
      ptr_sel_i = 2'h1;
      ptr_mode_i = ptr_mode_t'(k);
      ptr_disp_i = 6'h05;
      tick();
      `CHK("ptr_addr_o", 16'(k == 0 ? p + 5 : k == 1 ? p : p - 1), ptr_addr_o)
      p = k == 1 ? p + 1 : k == 2 ? p - 1 : p;
      reg_m[28] = p % 256;
      reg_m[29] = p / 256;
      dchk(28);
      dchk(29);
    end
    dwrite(30, 'h34);
    dwrite(31, 'h12);
    dchk(31);
    `CHK("table_addr_o", 16'h1234, table_addr_o)
    io_rd_i = 1'b1;
    io_addr_i = 6'h10;
    p = io_rdata_i;
    tick();
    `CHK("periph_rd_o", 1'b1, periph_rd_o)
    `CHK("data_rdata_o", 8'(p), data_rdata_o)
    conclude();
  end
endmodule
